/* power_mode_and_reset_control.sv */
`timescale 1ns/1ps
// Function
// - four modes: active, idle, suspend, stop
// - active: clock runs, cpu runs
// - idle bit halts cpu; interrupt/reset exits
// - suspend bit stops clock; wake/ext/mcd exits
// - stop bit kills oscillator; ext/mcd exits
// - nine reset sources accepted
// - por, pin, flash error cannot disable
// - watchdog lock holds until power-on
// - debug halt stalls peripherals except adc/twi
// - rtc alarm resets or wakes, per config
module power_mode_and_reset_control
  import pmrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic por_detect,
  input wire logic supply_low,
  input wire logic missing_clock_detect,
  input wire logic cmp0_level,
  input wire logic rtc_alarm,
  input wire logic rtc_clock_loss,
  input wire logic ext_reset_n,
  input wire logic wake_event,
  input wire logic watchdog_timer_expired,
  input wire logic flash_access_error,
  input wire logic irq_pending,
  input wire logic debug_halt,
  output logic cpu_halt,
  output logic system_clock_run,
  output logic osc_run,
  output logic digital_off,
  output logic periph_stall,
  output logic sys_reset,
  output logic [3:0] power_mode,
  output logic irq
);

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_PWR, OFS_OSC, OFS_RSTEN, OFS_CAUSE, OFS_LOCK,
      OFS_RTC, OFS_IRQST, OFS_IRQMSK, OFS_MODE, OFS_SWRST: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ---------------------------------------------------------------
  // synchronised pins and reset collection
  // ---------------------------------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;
  rst_src_if rs ();

  assign pin_raw = {wake_event, ext_reset_n, rtc_clock_loss, rtc_alarm,
                    cmp0_level, missing_clock_detect, supply_low, por_detect};

  pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  reset_collect u_coll (
    .sys_clk(sys_clk),
    .rst(rst),
    .rs(rs.collector)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mode_t mode_ff;
  mode_t nxt_mode;
  logic idle_req_ff;
  logic stop_req_ff;
  logic susp_req_ff;
  logic [NSRC-1:0] rsten_ff;
  logic wdt_lock_ff;
  logic rtc_rst_cfg_ff;
  logic rtc_wake_cfg_ff;
  logic sw_rst_ff;
  logic [IRQ_W-1:0] irq_st_ff;
  logic [IRQ_W-1:0] irq_msk_ff;
  logic [IRQ_W-1:0] nxt_irq_st;
  logic [IRQ_W-1:0] irq_set;
  logic [7:0] hold_ff;
  logic dev_rst;
  logic wake;
  logic do_wr;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic aw_have_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_have_ff;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] rd_val;

  assign dev_rst = rs.hit;
  assign wake = pin_s[PIN_WAKE] | (pin_s[PIN_ALARM] & rtc_wake_cfg_ff);
  assign do_wr = aw_have_ff & w_have_ff & ~s_axi_bvalid;
  assign wmask = lane_mask(wstrb_ff);
  assign wval = wdata_ff & wmask;

  // ---------------------------------------------------------------
  // reset source vector
  // ---------------------------------------------------------------
  always_comb begin
    rs.src = '0;
    rs.src[SRC_POR] = pin_s[PIN_POR];
    rs.src[SRC_VDD] = pin_s[PIN_VDD];
    rs.src[SRC_WDT] = watchdog_timer_expired;
    rs.src[SRC_MCD] = pin_s[PIN_MCD];
    rs.src[SRC_CMP] = pin_s[PIN_CMP];
    rs.src[SRC_RTC] = (pin_s[PIN_ALARM] & rtc_rst_cfg_ff) | pin_s[PIN_CLKLOSS];
    rs.src[SRC_SW] = sw_rst_ff;
    rs.src[SRC_EXT] = ~pin_s[PIN_EXT_N];
    rs.src[SRC_FLASH] = flash_access_error;
  end

  always_comb begin
    rs.enable = rsten_ff;
    rs.enable[SRC_WDT] = rsten_ff[SRC_WDT] | wdt_lock_ff;
    rs.allowed = SRC_ALL;
    if (mode_ff == MODE_SUSPEND || mode_ff == MODE_STOP) begin
      rs.allowed = SRC_LOWPWR;
    end
  end

  // ---------------------------------------------------------------
  // mode state machine
  // ---------------------------------------------------------------
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      MODE_ACTIVE: begin
        if (stop_req_ff) begin
          nxt_mode = MODE_STOP;
        end else if (susp_req_ff) begin
          nxt_mode = MODE_SUSPEND;
        end else if (idle_req_ff) begin
          nxt_mode = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (irq_pending || dev_rst) begin
          nxt_mode = MODE_ACTIVE;
        end
      end
      MODE_SUSPEND: begin
        if (wake || dev_rst) begin
          nxt_mode = MODE_ACTIVE;
        end
      end
      MODE_STOP: begin
        if (dev_rst) begin
          nxt_mode = MODE_ACTIVE;
        end
      end
      default: nxt_mode = MODE_ACTIVE;
    endcase
    if (hold_ff != '0) begin
      nxt_mode = MODE_ACTIVE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= MODE_ACTIVE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpu_halt <= 1'b0;
      system_clock_run <= 1'b1;
      osc_run <= 1'b1;
      digital_off <= 1'b0;
      power_mode <= MODE_ACTIVE;
    end else begin
      cpu_halt <= (nxt_mode != MODE_ACTIVE);
      system_clock_run <= (nxt_mode == MODE_ACTIVE) || (nxt_mode == MODE_IDLE);
      osc_run <= (nxt_mode != MODE_STOP);
      digital_off <= (nxt_mode == MODE_STOP);
      power_mode <= nxt_mode;
    end
  end

  // debug stall; adc and twi are left off this line
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      periph_stall <= 1'b0;
    end else begin
      periph_stall <= debug_halt;
    end
  end

  // ---------------------------------------------------------------
  // device reset stretch
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_ff <= '0;
      sys_reset <= 1'b0;
    end else if (dev_rst) begin
      hold_ff <= RST_HOLD_CNT;
      sys_reset <= 1'b1;
    end else begin
      if (hold_ff != '0) begin
        hold_ff <= hold_ff - 8'd1;
      end
      sys_reset <= (hold_ff > 8'd1);
    end
  end

  // ---------------------------------------------------------------
  // mode request bits
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_req_ff <= 1'b0;
      stop_req_ff <= 1'b0;
      susp_req_ff <= 1'b0;
    end else if (dev_rst || (mode_ff != MODE_ACTIVE && nxt_mode == MODE_ACTIVE)) begin
      idle_req_ff <= 1'b0;
      stop_req_ff <= 1'b0;
      susp_req_ff <= 1'b0;
    end else if (do_wr && aw_addr_ff == OFS_PWR && wstrb_ff[0]) begin
      idle_req_ff <= wdata_ff[PWR_IDLE_BIT];
      stop_req_ff <= wdata_ff[PWR_STOP_BIT];
    end else if (do_wr && aw_addr_ff == OFS_OSC && wstrb_ff[0]) begin
      susp_req_ff <= wdata_ff[OSC_SUSP_BIT];
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsten_ff <= RSTEN_RST;
      rtc_rst_cfg_ff <= 1'b0;
      rtc_wake_cfg_ff <= 1'b0;
    end else if (do_wr && aw_addr_ff == OFS_RSTEN) begin
      rsten_ff <= (rsten_ff & ~wmask[NSRC-1:0]) | wval[NSRC-1:0];
    end else if (do_wr && aw_addr_ff == OFS_RTC && wstrb_ff[0]) begin
      rtc_rst_cfg_ff <= wdata_ff[RTC_RST_BIT];
      rtc_wake_cfg_ff <= wdata_ff[RTC_WAKE_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdt_lock_ff <= 1'b0;
    end else if (pin_s[PIN_POR]) begin
      wdt_lock_ff <= 1'b0;
    end else if (do_wr && aw_addr_ff == OFS_LOCK && wval[LOCK_WDT_BIT]) begin
      wdt_lock_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sw_rst_ff <= 1'b0;
    end else begin
      sw_rst_ff <= do_wr && aw_addr_ff == OFS_SWRST && wval[SWRST_BIT];
    end
  end

  // ---------------------------------------------------------------
  // interrupts: set beats write-one-to-clear
  // ---------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_IDLE_EXIT] = (mode_ff == MODE_IDLE) && (nxt_mode == MODE_ACTIVE);
    irq_set[IRQ_SUSP_EXIT] = (mode_ff == MODE_SUSPEND) && (nxt_mode == MODE_ACTIVE);
    irq_set[IRQ_STOP_EXIT] = (mode_ff == MODE_STOP) && (nxt_mode == MODE_ACTIVE);
    irq_set[IRQ_RESET] = dev_rst;
    nxt_irq_st = irq_st_ff;
    if (do_wr && aw_addr_ff == OFS_IRQST) begin
      nxt_irq_st = irq_st_ff & ~wval[IRQ_W-1:0];
    end
    nxt_irq_st = nxt_irq_st | irq_set;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_st_ff <= '0;
      irq <= 1'b0;
    end else begin
      irq_st_ff <= nxt_irq_st;
      irq <= |(nxt_irq_st & irq_msk_ff);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_msk_ff <= '0;
    end else if (do_wr && aw_addr_ff == OFS_IRQMSK) begin
      irq_msk_ff <= (irq_msk_ff & ~wmask[IRQ_W-1:0]) | wval[IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_have_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_have_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_have_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      w_have_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_have_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_have_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    case (s_axi_araddr)
      OFS_PWR: begin
        rd_val[PWR_IDLE_BIT] = idle_req_ff;
        rd_val[PWR_STOP_BIT] = stop_req_ff;
      end
      OFS_OSC: rd_val[OSC_SUSP_BIT] = susp_req_ff;
      OFS_RSTEN: rd_val[NSRC-1:0] = rs.enable;
      OFS_CAUSE: rd_val[NSRC-1:0] = rs.cause;
      OFS_LOCK: rd_val[LOCK_WDT_BIT] = wdt_lock_ff;
      OFS_RTC: begin
        rd_val[RTC_RST_BIT] = rtc_rst_cfg_ff;
        rd_val[RTC_WAKE_BIT] = rtc_wake_cfg_ff;
      end
      OFS_IRQST: rd_val[IRQ_W-1:0] = irq_st_ff;
      OFS_IRQMSK: rd_val[IRQ_W-1:0] = irq_msk_ff;
      OFS_MODE: rd_val[3:0] = mode_ff;
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // power_mode_and_reset_control

/* pmrc_pkg.sv */
package pmrc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned RST_HOLD_NS = 200;
  localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] RST_HOLD_CNT = 8'(RST_HOLD_CYC);

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_PWR = 8'h00;
  localparam logic [7:0] OFS_OSC = 8'h04;
  localparam logic [7:0] OFS_RSTEN = 8'h08;
  localparam logic [7:0] OFS_CAUSE = 8'h0C;
  localparam logic [7:0] OFS_LOCK = 8'h10;
  localparam logic [7:0] OFS_RTC = 8'h14;
  localparam logic [7:0] OFS_IRQST = 8'h18;
  localparam logic [7:0] OFS_IRQMSK = 8'h1C;
  localparam logic [7:0] OFS_MODE = 8'h20;
  localparam logic [7:0] OFS_SWRST = 8'h24;

  localparam int unsigned PWR_IDLE_BIT = 0;
  localparam int unsigned PWR_STOP_BIT = 1;
  localparam int unsigned OSC_SUSP_BIT = 5;
  localparam int unsigned LOCK_WDT_BIT = 0;
  localparam int unsigned RTC_RST_BIT = 0;
  localparam int unsigned RTC_WAKE_BIT = 1;
  localparam int unsigned SWRST_BIT = 0;

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------
  localparam int unsigned NSRC = 9;
  localparam int unsigned SRC_POR = 0;
  localparam int unsigned SRC_VDD = 1;
  localparam int unsigned SRC_WDT = 2;
  localparam int unsigned SRC_MCD = 3;
  localparam int unsigned SRC_CMP = 4;
  localparam int unsigned SRC_RTC = 5;
  localparam int unsigned SRC_SW = 6;
  localparam int unsigned SRC_EXT = 7;
  localparam int unsigned SRC_FLASH = 8;
  localparam logic [NSRC-1:0] SRC_ALWAYS = 9'h181;
  localparam logic [NSRC-1:0] SRC_LOWPWR = 9'h089;
  localparam logic [NSRC-1:0] SRC_ALL = 9'h1FF;
  localparam logic [NSRC-1:0] RSTEN_RST = 9'h1FF;

  // ---------------------------------------------------------------
  // pins from outside the clock domain
  // ---------------------------------------------------------------
  localparam int unsigned NPIN = 8;
  localparam int unsigned PIN_POR = 0;
  localparam int unsigned PIN_VDD = 1;
  localparam int unsigned PIN_MCD = 2;
  localparam int unsigned PIN_CMP = 3;
  localparam int unsigned PIN_ALARM = 4;
  localparam int unsigned PIN_CLKLOSS = 5;
  localparam int unsigned PIN_EXT_N = 6;
  localparam int unsigned PIN_WAKE = 7;
  localparam logic [NPIN-1:0] PIN_IDLE = 8'h40;

  // ---------------------------------------------------------------
  // interrupt status layout
  // ---------------------------------------------------------------
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_IDLE_EXIT = 0;
  localparam int unsigned IRQ_SUSP_EXIT = 1;
  localparam int unsigned IRQ_STOP_EXIT = 2;
  localparam int unsigned IRQ_RESET = 3;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    MODE_ACTIVE = 4'b0001,
    MODE_IDLE = 4'b0010,
    MODE_SUSPEND = 4'b0100,
    MODE_STOP = 4'b1000
  } mode_t;

endpackage

/* rst_src_if.sv */
`timescale 1ns/1ps
interface rst_src_if;
  import pmrc_pkg::*;
  logic [NSRC-1:0] src;
  logic [NSRC-1:0] enable;
  logic [NSRC-1:0] allowed;
  logic hit;
  logic [NSRC-1:0] cause;
  modport collector (input src, input enable, input allowed, output hit, output cause);
  modport owner (output src, output enable, output allowed, input hit, input cause);
endinterface

/* pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
  import pmrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [NPIN-1:0] async_in,
  output logic [NPIN-1:0] sync_out
);
  // ---------------------------------------------------------------
  // two-stage synchroniser per pin
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    logic meta_ff;
    logic stab_ff;
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        meta_ff <= PIN_IDLE[i];
        stab_ff <= PIN_IDLE[i];
      end else begin
        meta_ff <= async_in[i];
        stab_ff <= meta_ff;
      end
    end
    assign sync_out[i] = stab_ff;
  end
endmodule // pin_sync

/* reset_collect.sv */
`timescale 1ns/1ps
module reset_collect
  import pmrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  rst_src_if.collector rs
);
  logic [NSRC-1:0] qual;
  logic hit_ff;
  logic [NSRC-1:0] cause_ff;

  // ---------------------------------------------------------------
  // qualify sources
  // ---------------------------------------------------------------
  assign qual = rs.src & (rs.enable | SRC_ALWAYS) & rs.allowed;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= |qual;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cause_ff <= '0;
    end else if (|qual) begin
      cause_ff <= qual;
    end
  end

  assign rs.hit = hit_ff;
  assign rs.cause = cause_ff;
endmodule // reset_collect

/* pmrc_monitor.sv */
`timescale 1ns/1ps
module pmrc_monitor
  import pmrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic irq_pending,
  input wire logic flash_access_error,
  input wire logic debug_halt,
  input wire logic cpu_halt,
  input wire logic system_clock_run,
  input wire logic osc_run,
  input wire logic digital_off,
  input wire logic periph_stall,
  input wire logic sys_reset,
  input wire logic [3:0] power_mode
);
  // ---------------------------------------------------------------
  // mode and reset checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seq_idle_wait;
    power_mode == 4'h2 && irq_pending;
  endsequence
  sequence seq_back_active;
    ##[1:3] power_mode == 4'h1;
  endsequence

  chk_mode_one_hot: assert property ($onehot(power_mode))
    else $error("power mode not one-hot");
  chk_active_runs: assert property (power_mode == 4'h1 |-> system_clock_run && !cpu_halt)
    else $error("active mode outputs wrong");
  chk_idle_halts: assert property (power_mode == 4'h2 |-> cpu_halt && system_clock_run)
    else $error("idle mode outputs wrong");
  chk_suspend_clock: assert property (power_mode == 4'h4 |-> !system_clock_run && osc_run)
    else $error("suspend mode outputs wrong");
  chk_stop_all_off: assert property (power_mode == 4'h8 |-> digital_off && !osc_run)
    else $error("stop mode outputs wrong");
  chk_idle_exit: assert property (seq_idle_wait |-> seq_back_active)
    else $error("idle not left on interrupt");
  chk_flash_reset: assert property (flash_access_error && power_mode[1:0] != 2'b00
    |-> ##[1:3] sys_reset)
    else $error("flash error gave no reset");
  chk_reset_stretch: assert property ($rose(sys_reset) |-> sys_reset [*8])
    else $error("reset pulse too short");
  chk_stall_follow: assert property (1'b1 |=> periph_stall == $past(debug_halt))
    else $error("stall does not follow debug halt");
endmodule // pmrc_monitor

/* core_side_model.sv */
`timescale 1ns/1ps
module core_side_model
  import pmrc_pkg::*;
(
  input wire logic [NPIN+1:0] req,
  input wire logic int_req,
  input wire logic dbg_req,
  output logic por_detect,
  output logic supply_low,
  output logic missing_clock_detect,
  output logic cmp0_level,
  output logic rtc_alarm,
  output logic rtc_clock_loss,
  output logic ext_reset_n,
  output logic wake_event,
  output logic watchdog_timer_expired,
  output logic flash_access_error,
  output logic irq_pending,
  output logic debug_halt
);
  // ---------------------------------------------------------------
  // sources, low bits pins, then watchdog and flash
  // ---------------------------------------------------------------
  assign por_detect = req[PIN_POR];
  assign supply_low = req[PIN_VDD];
  assign missing_clock_detect = req[PIN_MCD];
  assign cmp0_level = req[PIN_CMP];
  assign rtc_alarm = req[PIN_ALARM];
  assign rtc_clock_loss = req[PIN_CLKLOSS];
  assign ext_reset_n = ~req[PIN_EXT_N];
  assign wake_event = req[PIN_WAKE];
  assign watchdog_timer_expired = req[NPIN];
  assign flash_access_error = req[NPIN+1];
  assign irq_pending = int_req;
  assign debug_halt = dbg_req;
endmodule // core_side_model

/* power_mode_and_reset_control_tb.sv */
`timescale 1ns/1ps
module power_mode_and_reset_control_tb;
  import pmrc_pkg::*;
  logic sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, power_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_q, rresp_q;
  logic por_detect, supply_low, missing_clock_detect, cmp0_level, rtc_alarm, rtc_clock_loss;
  logic ext_reset_n, wake_event, watchdog_timer_expired, flash_access_error, irq_pending;
  logic debug_halt, cpu_halt, system_clock_run, osc_run, digital_off, periph_stall;
  logic sys_reset, irq, int_req, dbg_req;
  logic [NPIN+1:0] req;
  int bad_count = 0;
  int comparisons = 0;
  int srcs[6] = '{PIN_VDD, PIN_MCD, PIN_CMP, PIN_CLKLOSS, NPIN, PIN_POR};

  power_mode_and_reset_control i_power_mode_and_reset_control (.*);
  core_side_model i_core_side_model (.*);

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task stop_test;
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task timed_out(input string nm);
    bad_count++;
    $display("MISMATCH %s expected answer seen timeout", nm);
    stop_test;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    bresp_q = s_axi_bresp;
    if (n >= 50) timed_out("write");
  endtask
  task rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    rresp_q = s_axi_rresp;
    if (n >= 50) timed_out("read");
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, d);
  endtask
  task wait_mode(input logic [3:0] m);
    int n;
    n = 0;
    while (power_mode !== m && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20) timed_out("mode");
    @(posedge sys_clk);
    chk("power_mode", m, power_mode);
  endtask
  task ppin(input int i);
    req[i] <= 1'b1;
    @(posedge sys_clk);
    req[i] <= 1'b0;
  endtask
  task expect_rst(input logic e);
    int n;
    logic seen;
    seen = 1'b0;
    for (n = 0; n < 8; n++) begin
      @(posedge sys_clk);
      if (sys_reset === 1'b1) seen = 1'b1;
    end
    chk("sys_reset", e, seen);
    n = 0;
    while (sys_reset !== 1'b0 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 60) timed_out("reset end");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset_state;
    rchk("mode", OFS_MODE, 32'h0000_0001);
    rchk("rsten", OFS_RSTEN, 32'h0000_01ff);
    rd(8'hfc);
    chk("rresp", RESP_SLVERR, rresp_q);
    wr(8'hf8, 32'h0000_0001);
    chk("bresp", RESP_SLVERR, bresp_q);
    chk("clock_run", 1, system_clock_run);
  endtask
  task t_idle;
    wr(OFS_PWR, 32'h0000_0001);
    wait_mode(4'h2);
    chk("cpu_halt", 1, cpu_halt);
    int_req <= 1'b1;
    wait_mode(4'h1);
    int_req <= 1'b0;
    rchk("pwr", OFS_PWR, 32'h0000_0000);
    wr(OFS_PWR, 32'h0000_0001);
    wait_mode(4'h2);
    ppin(NPIN + 1);
    expect_rst(1);
    chk("power_mode", 4'h1, power_mode);
  endtask
  task t_suspend;
    wr(OFS_OSC, 32'h0000_0020);
    wait_mode(4'h4);
    chk("clock_run", 0, system_clock_run);
    ppin(NPIN + 1);
    expect_rst(0);
    ppin(PIN_WAKE);
    wait_mode(4'h1);
    rchk("osc", OFS_OSC, 32'h0000_0000);
    wr(OFS_RTC, 32'h0000_0002);
    wr(OFS_OSC, 32'h0000_0020);
    wait_mode(4'h4);
    ppin(PIN_ALARM);
    wait_mode(4'h1);
    wr(OFS_RTC, 32'h0000_0001);
    ppin(PIN_ALARM);
    expect_rst(1);
    wr(OFS_RTC, 32'h0000_0000);
  endtask
  task t_stop;
    wr(OFS_PWR, 32'h0000_0002);
    wait_mode(4'h8);
    chk("osc_run", 0, osc_run);
    ppin(PIN_WAKE);
    ppin(NPIN + 1);
    expect_rst(0);
    chk("power_mode", 4'h8, power_mode);
    ppin(PIN_EXT_N);
    expect_rst(1);
    chk("power_mode", 4'h1, power_mode);
    rchk("pwr", OFS_PWR, 32'h0000_0000);
  endtask
  task t_sources;
    wr(OFS_RSTEN, 32'h0000_0000);
    ppin(NPIN);
    expect_rst(0);
    wr(OFS_SWRST, 32'h0000_0001);
    expect_rst(0);
    ppin(NPIN + 1);
    expect_rst(1);
    rd(OFS_CAUSE);
    chk("cause_flash", 1, d[SRC_FLASH]);
    wr(OFS_RSTEN, 32'h0000_01ff);
    wr(OFS_SWRST, 32'h0000_0001);
    expect_rst(1);
    foreach (srcs[i]) begin
      ppin(srcs[i]);
      expect_rst(1);
    end
  endtask
  task t_lock;
    wr(OFS_RSTEN, 32'h0000_0000);
    wr(OFS_LOCK, 32'h0000_0001);
    rchk("rsten", OFS_RSTEN, 32'h0000_0004);
    ppin(NPIN);
    expect_rst(1);
    wr(OFS_LOCK, 32'h0000_0000);
    rchk("lock", OFS_LOCK, 32'h0000_0001);
    ppin(PIN_POR);
    expect_rst(1);
    rchk("lock", OFS_LOCK, 32'h0000_0000);
    wr(OFS_RSTEN, 32'h0000_01ff);
  endtask
  task t_debug_irq;
    dbg_req <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("periph_stall", 1, periph_stall);
    dbg_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("periph_stall", 0, periph_stall);
    chk("irq", 0, irq);
    wr(OFS_IRQMSK, 32'h0000_000f);
    repeat (2) @(posedge sys_clk);
    chk("irq", 1, irq);
    wr(OFS_IRQST, 32'h0000_000f);
    rchk("irq_status", OFS_IRQST, 32'h0000_0000);
    chk("irq", 0, irq);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, int_req, dbg_req} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset_state;
    t_idle;
    t_suspend;
    t_stop;
    t_sources;
    t_lock;
    t_debug_irq;
    stop_test;
  end
endmodule // power_mode_and_reset_control_tb

bind power_mode_and_reset_control pmrc_monitor i_pmrc_monitor (.sys_clk, .rst, .irq_pending,
  .flash_access_error, .debug_halt, .cpu_halt, .system_clock_run, .osc_run, .digital_off,
  .periph_stall, .sys_reset, .power_mode);
